// ==== rtl/esg_spark_gen.v ====
/*
 * Engine-synchronous ignition command generator: one pulse per engine
 * cycle, placed by crank angle, with on-time floor and ceiling limits.
 * Assumes crank bundle and unlock token synchronous to ref_clk, the token
 * delayed by one register stage, and software writing register values.
 */
// Operation
// - Output is active only while the unlock token is valid; otherwise it sits at the idle level.
// - Pulses only while ignition enable is set; cleared by default.
// - Window select clear: pulse from trail angle and on-time, lead ignored.
// - Window select set: pulse from lead and trail angle, on-time ignored.
// - Polarity clear gives high pulse; set gives low pulse, idle high.
// - Window mode leading edge occurs when crank reaches lead angle.
// - Trailing edge at trail angle unless an on-time limit overrides.
// - On-time mode start computed from on-time and speed, back from trail.
// - Trail angle beats requested on-time when speed changes mid-pulse.
// - Pulse held past trail angle until floor on-time has elapsed.
// - Pulse ended at once when ceiling on-time is reached.
// - Cutoff angle ends all activity and rearms for next cycle.
// - On-times counted in clock ticks, truncated to 24 bits.
// - One Boolean ignition command output for a digital output channel.
// - Logic evaluated every clock; all tick counts reference that clock.
// - Angles in crank ticks; cycle spans the tracker's ticks per cycle.
`include "esg_map.vh"

module esg_spark_gen #(
	parameter CAT_W = `ESG_CAT_W,
	parameter ON_W = `ESG_ON_W
) (
	input wire ref_clk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata,
	input wire key_valid,
	input wire [CAT_W-1:0] crank_pos,
	input wire crank_sync,
	input wire [CAT_W-1:0] cycle_ticks,
	output wire ignition_cmd_out
);
	localparam PROD_W = CAT_W + ON_W;

	// Forward distance in crank ticks, wrapping at the cycle length
	function [CAT_W-1:0] ang_dist;
		input [CAT_W-1:0] from_pos;
		input [CAT_W-1:0] to_pos;
		input [CAT_W-1:0] span;
		begin
			if (to_pos >= from_pos)
				ang_dist = to_pos - from_pos;
			else
				ang_dist = to_pos + span - from_pos;
		end
	endfunction

	// Control and parameter registers
	reg ignition_cmd_enable_reg;
	reg angle_window_select_reg;
	reg invert_polarity_reg;
	reg [CAT_W-1:0] lead_angle_reg;
	reg [CAT_W-1:0] trail_angle_reg;
	reg [CAT_W-1:0] cycle_reset_angle_reg;
	reg [ON_W-1:0] req_on_time_reg;
	reg [ON_W-1:0] floor_on_time_reg;
	reg [ON_W-1:0] ceiling_on_time_reg;
	reg [31:0] rdata_reg;

	// Sequencer state
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg ceil_hit_reg;
	reg ceil_hit_next;
	reg floor_ext_reg;
	reg floor_ext_next;
	reg out_reg;
	reg timer_clear;

	wire [CAT_W-1:0] step_pos;
	wire pos_step;
	wire [ON_W-1:0] period;
	wire [ON_W-1:0] on_count;
	wire at_lead;
	wire at_trail;
	wire at_cutoff;
	wire allowed;
	wire [CAT_W-1:0] to_trail;
	wire [PROD_W-1:0] eta_ticks;
	wire dwell_due;
	wire floor_met;
	wire ceil_met;
	wire pulse_on;

	esg_speed_meter #(
		.CAT_W(CAT_W),
		.ON_W(ON_W)
	) u_speed (
		.ref_clk(ref_clk),
		.reset(reset),
		.crank_pos(crank_pos),
		.crank_sync(crank_sync),
		.step_pos(step_pos),
		.pos_step(pos_step),
		.period(period)
	);

	esg_on_timer #(
		.ON_W(ON_W)
	) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(timer_clear),
		.run(pulse_on),
		.count(on_count)
	);

	// Register writes; on-times keep their low 24 bits only
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			ignition_cmd_enable_reg <= 1'b0;
			angle_window_select_reg <= 1'b0;
			invert_polarity_reg <= 1'b0;
			lead_angle_reg <= `ESG_ANGLE_RESET;
			trail_angle_reg <= `ESG_ANGLE_RESET;
			cycle_reset_angle_reg <= `ESG_ANGLE_RESET;
			req_on_time_reg <= `ESG_TIME_RESET;
			floor_on_time_reg <= `ESG_TIME_RESET;
			ceiling_on_time_reg <= `ESG_TIME_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`ESG_OFS_CTRL:
				begin
					ignition_cmd_enable_reg <= reg_wdata[`ESG_CTRL_ENABLE];
					angle_window_select_reg <= reg_wdata[`ESG_CTRL_WINDOW];
					invert_polarity_reg <= reg_wdata[`ESG_CTRL_INVERT];
				end
				`ESG_OFS_LEAD:
					lead_angle_reg <= reg_wdata[CAT_W-1:0];
				`ESG_OFS_TRAIL:
					trail_angle_reg <= reg_wdata[CAT_W-1:0];
				`ESG_OFS_CUTOFF:
					cycle_reset_angle_reg <= reg_wdata[CAT_W-1:0];
				`ESG_OFS_REQ_ON:
					req_on_time_reg <= reg_wdata[ON_W-1:0];
				`ESG_OFS_FLOOR:
					floor_on_time_reg <= reg_wdata[ON_W-1:0];
				`ESG_OFS_CEIL:
					ceiling_on_time_reg <= reg_wdata[ON_W-1:0];
				default:
					;
			endcase
		end
	end

	// Register reads, data in the following cycle only
	always @(posedge ref_clk)
	begin
		if (reset)
			rdata_reg <= 32'h00000000;
		else if (reg_rd)
		begin
			rdata_reg <= 32'h00000000;
			case (reg_addr)
				`ESG_OFS_CTRL:
				begin
					rdata_reg[`ESG_CTRL_ENABLE] <= ignition_cmd_enable_reg;
					rdata_reg[`ESG_CTRL_WINDOW] <= angle_window_select_reg;
					rdata_reg[`ESG_CTRL_INVERT] <= invert_polarity_reg;
				end
				`ESG_OFS_LEAD:
					rdata_reg[CAT_W-1:0] <= lead_angle_reg;
				`ESG_OFS_TRAIL:
					rdata_reg[CAT_W-1:0] <= trail_angle_reg;
				`ESG_OFS_CUTOFF:
					rdata_reg[CAT_W-1:0] <= cycle_reset_angle_reg;
				`ESG_OFS_REQ_ON:
					rdata_reg[ON_W-1:0] <= req_on_time_reg;
				`ESG_OFS_FLOOR:
					rdata_reg[ON_W-1:0] <= floor_on_time_reg;
				`ESG_OFS_CEIL:
					rdata_reg[ON_W-1:0] <= ceiling_on_time_reg;
				`ESG_OFS_STATUS:
				begin
					rdata_reg[`ESG_STAT_ACTIVE] <= pulse_on;
					rdata_reg[`ESG_STAT_STATE_HI:`ESG_STAT_STATE_LO] <= state_reg;
					rdata_reg[`ESG_STAT_KEY] <= key_valid;
					rdata_reg[`ESG_STAT_CEIL_HIT] <= ceil_hit_reg;
					rdata_reg[`ESG_STAT_FLOOR_EXT] <= floor_ext_reg;
				end
				`ESG_OFS_PERIOD:
					rdata_reg[ON_W-1:0] <= period;
				default:
					rdata_reg <= 32'h00000000;
			endcase
		end
		else
			rdata_reg <= 32'h00000000;
	end

	assign reg_rdata = rdata_reg;

	// Angle events, taken on each new crank tick position
	assign at_lead = pos_step && (step_pos == lead_angle_reg);
	assign at_trail = pos_step && (step_pos == trail_angle_reg);
	assign at_cutoff = pos_step && (step_pos == cycle_reset_angle_reg);
	assign allowed = key_valid && ignition_cmd_enable_reg;

	// Time left to the trail angle at the latest measured speed
	assign to_trail = ang_dist(step_pos, trail_angle_reg, cycle_ticks);
	assign eta_ticks = to_trail * period;
	assign dwell_due = pos_step && (eta_ticks <= {{CAT_W{1'b0}}, req_on_time_reg});

	assign floor_met = on_count >= floor_on_time_reg;
	assign ceil_met = on_count >= ceiling_on_time_reg;
	assign pulse_on = (state_reg == `ESG_S_ON) || (state_reg == `ESG_S_HOLD);

	// Sequencer: cutoff rearms, limits end the pulse, trail ends it
	always @*
	begin
		state_next = state_reg;
		ceil_hit_next = ceil_hit_reg;
		floor_ext_next = floor_ext_reg;
		timer_clear = 1'b0;
		case (state_reg)
			`ESG_S_DONE:
				;
			`ESG_S_ARM:
			begin
				if (allowed)
				begin
					if (angle_window_select_reg)
					begin
						// Trail before lead means no pulse this cycle
						if (at_lead && !at_trail)
							state_next = `ESG_S_ON;
						else if (at_trail)
							state_next = `ESG_S_DONE;
					end
					else if (at_trail)
						state_next = `ESG_S_DONE;
					else if (dwell_due)
						state_next = `ESG_S_ON;
				end
			end
			`ESG_S_ON:
			begin
				if (!allowed)
					state_next = `ESG_S_DONE;
				else if (ceil_met)
				begin
					state_next = `ESG_S_DONE;
					ceil_hit_next = 1'b1;
				end
				else if (at_trail)
				begin
					// Trail angle wins over requested on-time
					if (floor_met)
						state_next = `ESG_S_DONE;
					else
					begin
						state_next = `ESG_S_HOLD;
						floor_ext_next = 1'b1;
					end
				end
			end
			`ESG_S_HOLD:
			begin
				if (!allowed)
					state_next = `ESG_S_DONE;
				else if (ceil_met)
				begin
					state_next = `ESG_S_DONE;
					ceil_hit_next = 1'b1;
				end
				else if (floor_met)
					state_next = `ESG_S_DONE;
			end
			default:
				state_next = `ESG_S_DONE;
		endcase
		// Cutoff overrides everything and rearms the cycle
		if (at_cutoff)
		begin
			state_next = `ESG_S_ARM;
			ceil_hit_next = 1'b0;
			floor_ext_next = 1'b0;
			timer_clear = 1'b1;
		end
		else if (state_reg == `ESG_S_ARM)
			timer_clear = 1'b1;
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			// Wait for a cutoff so no partial pulse follows reset
			state_reg <= `ESG_S_DONE;
			ceil_hit_reg <= 1'b0;
			floor_ext_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ceil_hit_reg <= ceil_hit_next;
			floor_ext_reg <= floor_ext_next;
		end
	end

	// Registered command; idle level follows polarity
	always @(posedge ref_clk)
	begin
		if (reset)
			out_reg <= 1'b0;
		else
			out_reg <= (pulse_on && allowed) ^ invert_polarity_reg;
	end

	assign ignition_cmd_out = out_reg;
endmodule // esg_spark_gen

// ==== rtl/esg_map.vh ====
/*
 * Register offsets, field positions, reset values, widths and state codes
 * of the engine-synchronous ignition pulse generator.
 * Assumes a 32-bit register port, one aligned word per register.
 */
`ifndef ESG_MAP_VH
`define ESG_MAP_VH

// Byte addresses
`define ESG_OFS_CTRL 8'h00
`define ESG_OFS_LEAD 8'h04
`define ESG_OFS_TRAIL 8'h08
`define ESG_OFS_CUTOFF 8'h0c
`define ESG_OFS_REQ_ON 8'h10
`define ESG_OFS_FLOOR 8'h14
`define ESG_OFS_CEIL 8'h18
`define ESG_OFS_STATUS 8'h1c
`define ESG_OFS_PERIOD 8'h20

// Control fields
`define ESG_CTRL_ENABLE 0
`define ESG_CTRL_WINDOW 1
`define ESG_CTRL_INVERT 2
`define ESG_CTRL_RESET 3'h0

// Status fields
`define ESG_STAT_ACTIVE 0
`define ESG_STAT_STATE_LO 1
`define ESG_STAT_STATE_HI 2
`define ESG_STAT_KEY 3
`define ESG_STAT_CEIL_HIT 4
`define ESG_STAT_FLOOR_EXT 5

// Widths
`define ESG_ON_W 24
`define ESG_CAT_W 16

// Reset values of angles and on-times
`define ESG_ANGLE_RESET 16'h0000
`define ESG_TIME_RESET 24'h000000

// Sequencer states
`define ESG_S_DONE 2'h0
`define ESG_S_ARM 2'h1
`define ESG_S_ON 2'h2
`define ESG_S_HOLD 2'h3

`endif

// ==== rtl/esg_speed_meter.v ====
/*
 * Crank speed meter: clocks between successive crank tick positions.
 * Assumes crank position and its valid flag are synchronous to ref_clk.
 */
module esg_speed_meter #(
	parameter CAT_W = 16,
	parameter ON_W = 24
) (
	input wire ref_clk,
	input wire reset,
	input wire [CAT_W-1:0] crank_pos,
	input wire crank_sync,
	output wire [CAT_W-1:0] step_pos,
	output wire pos_step,
	output wire [ON_W-1:0] period
);
	reg [CAT_W-1:0] last_pos_reg;
	reg [ON_W-1:0] run_reg;
	reg [ON_W-1:0] period_reg;
	reg step_reg;
	wire moved;

	assign moved = crank_sync && (crank_pos != last_pos_reg);
	assign step_pos = last_pos_reg;
	assign pos_step = step_reg;
	assign period = period_reg;

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			last_pos_reg <= {CAT_W{1'b0}};
			run_reg <= {ON_W{1'b0}};
			period_reg <= {ON_W{1'b1}};
			step_reg <= 1'b0;
		end
		else
		begin
			step_reg <= moved;
			last_pos_reg <= crank_pos;
			if (moved)
			begin
				period_reg <= run_reg;
				run_reg <= {{(ON_W-1){1'b0}}, 1'b1};
			end
			// Saturate so a stalled engine reads as very slow
			else if (run_reg != {ON_W{1'b1}})
				run_reg <= run_reg + {{(ON_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // esg_speed_meter

// ==== rtl/esg_on_timer.v ====
/*
 * Saturating on-time counter in clock ticks.
 * Assumes clear and run come from the sequencer in the same clock domain.
 */
module esg_on_timer #(
	parameter ON_W = 24
) (
	input wire ref_clk,
	input wire reset,
	input wire clear,
	input wire run,
	output wire [ON_W-1:0] count
);
	reg [ON_W-1:0] count_reg;

	assign count = count_reg;

	always @(posedge ref_clk)
	begin
		if (reset || clear)
			count_reg <= {ON_W{1'b0}};
		else if (run && (count_reg != {ON_W{1'b1}}))
			count_reg <= count_reg + {{(ON_W-1){1'b0}}, 1'b1};
	end
endmodule // esg_on_timer

// ==== verification/esg_spark_gen_monitor.sv ====
/* Port checker of the ignition pulse generator.
   Assumes control values change only through reg_wr. */
module esg_mon #(
	parameter CAT_W = 16,
	parameter ON_W = 24
) (
	input logic ref_clk,
	input logic reset,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic key_valid,
	input logic [CAT_W-1:0] crank_pos,
	input logic crank_sync,
	input logic [CAT_W-1:0] cycle_ticks,
	input logic ignition_cmd_out
);
	logic [2:0] ctrl_reg;
	logic [CAT_W-1:0] lead_reg, trail_reg, cut_reg;
	logic [ON_W-1:0] floor_reg, ceil_reg;
	logic [ON_W:0] len_reg;
	logic [2:0] quiet_reg;
	logic act, quiet, top;
	assign act = ignition_cmd_out ^ ctrl_reg[2];
	assign quiet = quiet_reg == 3'h7;
	assign top = ceil_reg == {ON_W{1'b1}};
	// Shadow of the written settings
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			{ctrl_reg, lead_reg, trail_reg, cut_reg} <= '0;
			{floor_reg, ceil_reg, quiet_reg} <= '0;
		end
		else
		begin
			quiet_reg <= reg_wr ? 3'h0 : quiet_reg + {2'h0, !quiet};
			if (reg_wr)
			begin
				case (reg_addr)
					8'h00: ctrl_reg <= reg_wdata[2:0];
					8'h04: lead_reg <= reg_wdata[CAT_W-1:0];
					8'h08: trail_reg <= reg_wdata[CAT_W-1:0];
					8'h0c: cut_reg <= reg_wdata[CAT_W-1:0];
					8'h14: floor_reg <= reg_wdata[ON_W-1:0];
					8'h18: ceil_reg <= reg_wdata[ON_W-1:0];
					default: ;
				endcase
			end
		end
	end
	always_ff @(posedge ref_clk)
		len_reg <= act ? len_reg + 1'b1 : '0;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_key;
		(!key_valid && !reg_wr)[*3] |=> !act;
	endproperty
	a_key: assert property (p_key)
		else $error("active without token");
	property p_en;
		(!ctrl_reg[0] && !reg_wr)[*3] |=> !act;
	endproperty
	a_en: assert property (p_en)
		else $error("active while disabled");
	property p_lead;
		ctrl_reg[1] && quiet && $rose(act) |-> $past(crank_pos, 3) == lead_reg;
	endproperty
	a_lead: assert property (p_lead)
		else $error("leading edge off lead angle");
	property p_trail;
		$fell(act) && key_valid && ctrl_reg[0] && quiet && floor_reg == 0
		&& top && $past(crank_pos, 3) != cut_reg
		|-> $past(crank_pos, 3) == trail_reg;
	endproperty
	a_trail: assert property (p_trail)
		else $error("trailing edge off trail angle");
	property p_floor;
		$fell(act) && key_valid && quiet && top
		&& $past(crank_pos, 3) != cut_reg |-> len_reg >= floor_reg;
	endproperty
	a_floor: assert property (p_floor)
		else $error("pulse shorter than floor");
	property p_ceil;
		act && quiet |-> len_reg <= ceil_reg;
	endproperty
	a_ceil: assert property (p_ceil)
		else $error("pulse longer than ceiling");
	property p_cut;
		(crank_pos == cut_reg && !reg_wr)[*4] |=> !act;
	endproperty
	a_cut: assert property (p_cut)
		else $error("active at cutoff");
	property p_rd;
		reg_rd && reg_addr == 8'h00 |=> reg_rdata == {29'h0, $past(ctrl_reg)};
	endproperty
	a_rd: assert property (p_rd)
		else $error("control readback wrong");
	c_win: cover property (ctrl_reg[1] && $rose(act));
	c_time: cover property (!ctrl_reg[1] && $rose(act));
	c_inv: cover property (ctrl_reg[2] && $fell(act));
endmodule // esg_mon
bind esg_spark_gen esg_mon #(.CAT_W(CAT_W), .ON_W(ON_W)) i_mon (
	.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .key_valid(key_valid), .crank_pos(crank_pos),
	.crank_sync(crank_sync), .cycle_ticks(cycle_ticks),
	.ignition_cmd_out(ignition_cmd_out));

// ==== verification/esg_crank_model.sv ====
/* Crank position tracker and unlock token source.
   Assumes one clock; a tick lasts HOLD clocks. */
module esg_crank_model #(
	parameter HOLD = 5,
	parameter TICKS = 200
) (
	input logic ref_clk,
	input logic reset,
	input logic tok,
	output logic [15:0] crank_pos,
	output logic crank_sync,
	output logic [15:0] cycle_ticks,
	output logic key_valid
);
	int cnt_reg;
	assign cycle_ticks = 16'(TICKS);
	always @(posedge ref_clk)
	begin
		key_valid <= tok;
		crank_sync <= !reset;
		if (reset)
		begin
			cnt_reg <= 0;
			crank_pos <= 16'h0000;
		end
		else if (cnt_reg == HOLD - 1)
		begin
			cnt_reg <= 0;
			crank_pos <= crank_pos == TICKS - 1 ? 16'h0 : crank_pos + 16'h1;
		end
		else
			cnt_reg <= cnt_reg + 1;
	end
endmodule // esg_crank_model

// ==== verification/test_esg_spark_gen.sv ====
/* Self-checking bench of the ignition pulse generator.
   Assumes the crank model steps one tick every five clocks. */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
	$display("BAD %0t %h %h", $time, a, e); end end
module test_esg_spark_gen;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] CUT = 16'h0078;
	logic ref_clk, reset, reg_wr, reg_rd, tok, inv, crank_sync;
	logic key_valid, ignition_cmd_out;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] crank_pos, cycle_ticks, sp, ep;
	int errors, compares, len;
	esg_spark_gen i_dut (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_valid(key_valid),
		.crank_pos(crank_pos), .crank_sync(crank_sync),
		.cycle_ticks(cycle_ticks), .ignition_cmd_out(ignition_cmd_out));
	esg_crank_model i_crank (.ref_clk(ref_clk), .reset(reset), .tok(tok),
		.crank_pos(crank_pos), .crank_sync(crank_sync),
		.cycle_ticks(cycle_ticks), .key_valid(key_valid));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task end_sim;
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge ref_clk);
	endtask
	// One engine cycle from cutoff: active length, start and end position
	task meas;
		int n;
		logic a, p;
		{len, p, sp, ep, n} = '0;
		while (crank_pos !== CUT && n < 1100)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 1100)
		begin
			errors++;
			end_sim;
		end
		// Skip the tail of a pulse held over from the cycle before
		repeat (2) @(posedge ref_clk);
		repeat (1010)
		begin
			@(posedge ref_clk);
			#1 a = ignition_cmd_out ^ inv;
			if (a && !p)
				sp = crank_pos;
			if (!a && p && ep == 0)
				ep = crank_pos;
			len += a;
			p = a;
		end
	endtask
	initial
	begin
		{reset, tok} = 2'h3;
		{reg_wr, reg_rd, inv, errors, compares} = '0;
		{reg_addr, reg_wdata} = '0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(8'h00, d);
		`CHK(d, 32'h0)
		rd(8'h24, d);
		`CHK(d, 32'h0)
		wr(8'h04, 32'h14);
		wr(8'h08, 32'h28);
		wr(8'h0c, {16'h0, CUT});
		wr(8'h18, 32'hffffff);
		meas;
		`CHK(len, 0)
		rd(8'h1c, d);
		`CHK(d, 32'ha)
		rd(8'h20, d);
		`CHK(d, 32'h5)
		wr(8'h00, 32'h3);
		rd(8'h00, d);
		`CHK(d, 32'h3)
		meas;
		`CHK(len, 100)
		`CHK(sp, 16'h14)
		`CHK(ep, 16'h28)
		inv = 1'b1;
		wr(8'h00, 32'h7);
		meas;
		`CHK(len, 100)
		`CHK(ignition_cmd_out, 1'b1)
		tok <= 1'b0;
		meas;
		`CHK(len, 0)
		`CHK(ignition_cmd_out, 1'b1)
		tok <= 1'b1;
		inv = 1'b0;
		wr(8'h00, 32'h3);
		wr(8'h14, 32'hc8);
		meas;
		`CHK(len >= 200 && len <= 201, 1'b1)
		wr(8'h14, 32'h7d0);
		meas;
		`CHK(ep, CUT)
		`CHK(len, 500)
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h1e);
		meas;
		`CHK(len >= 30 && len <= 31, 1'b1)
		wr(8'h18, 32'hffffff);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h5);
		wr(8'h10, 32'h01000032);
		meas;
		`CHK(sp, 16'h1e)
		`CHK(ep, 16'h28)
		`CHK(len, 50)
		end_sim;
	end
endmodule // test_esg_spark_gen
